// File: common/gpc_pkg.sv
package gpc_pkg;

////////////////////////////////////////////////////////////////////////////
// Rates and counts
localparam int GPC_SER_MHZ = 1250;
localparam int GPC_DESER = 10;
localparam int GPC_PAR_MHZ = GPC_SER_MHZ / GPC_DESER;
localparam int GPC_PHASES = 8;
localparam logic [3:0] GPC_BIT_LAST = 4'(GPC_DESER - 1);
localparam logic [3:0] GPC_ROLL_PT = 4'hA;
localparam logic [1:0] GPC_SLIP_WAIT = 2'h2;
localparam logic [2:0] GPC_ERR_LAST = 3'h3;
localparam logic [1:0] GPC_GOOD_LAST = 2'h3;

////////////////////////////////////////////////////////////////////////////
// Code groups, first line bit in bit 9
localparam logic [9:0] GPC_COMMA_NEG = 10'h0FA;
localparam logic [9:0] GPC_COMMA_POS = 10'h305;
localparam logic [6:0] GPC_C7_NEG = 7'h1F;
localparam logic [6:0] GPC_C7_POS = 7'h60;
localparam logic [7:0] GPC_K28_5 = 8'hBC;
localparam logic [5:0] GPC_K28_6B = 6'h0F;

////////////////////////////////////////////////////////////////////////////
// Register map and fields
localparam logic [1:0] GPC_A_CTRL = 2'h0;
localparam logic [1:0] GPC_A_STAT = 2'h1;
localparam int GPC_C_RXREV = 0;
localparam int GPC_C_AUTO = 1;
localparam int GPC_C_SLIPCLR = 2;
localparam logic [15:0] GPC_CTRL_RST = 16'h0002;
localparam int GPC_S_SYNC = 0;
localparam int GPC_S_ROLL = 1;
localparam int GPC_S_SLIP = 2;
localparam int GPC_S_PHASE = 6;
localparam int GPC_S_LOCK = 9;

////////////////////////////////////////////////////////////////////////////
// Types
typedef enum logic [2:0] {
    GPC_LOS = 3'b000,
    GPC_ACQ1 = 3'b001,
    GPC_ACQ2 = 3'b010,
    GPC_SYNC = 3'b011
} gpc_sync_t;

typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [15:0] wdata;
} gpc_bus_t;

typedef struct packed {
    logic valid;
    logic k;
    logic [7:0] data;
} gpc_tx_t;

////////////////////////////////////////////////////////////////////////////
// Shared helpers
function automatic logic [9:0] rev10(input logic [9:0] w);
    for (int i = 0; i < 10; i++) begin
        rev10[i] = w[9 - i];
    end
endfunction : rev10

function automatic logic [3:0] popc(input logic [9:0] w);
    popc = 4'h0;
    for (int i = 0; i < 10; i++) begin
        popc = popc + {3'h0, w[i]};
    end
endfunction : popc

endpackage : gpc_pkg

// File: design/gpc_enc8b10b.sv
module gpc_enc8b10b
    import gpc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Characters in, code groups out with bit a in bit 9
    input wire gpc_tx_t tx_i,
    output logic [9:0] word_o,
    output logic vld_o
);

    typedef struct packed {
        logic rd_pos;
        logic [9:0] word;
        logic vld;
    } gpc_enc_st_t;

    gpc_enc_st_t st_r;
    gpc_enc_st_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Negative-disparity tables, first bit on the left
    function automatic logic [5:0] tab6(input logic [4:0] x);
        case (x)
            5'h00: tab6 = 6'b100111;
            5'h01: tab6 = 6'b011101;
            5'h02: tab6 = 6'b101101;
            5'h03: tab6 = 6'b110001;
            5'h04: tab6 = 6'b110101;
            5'h05: tab6 = 6'b101001;
            5'h06: tab6 = 6'b011001;
            5'h07: tab6 = 6'b111000;
            5'h08: tab6 = 6'b111001;
            5'h09: tab6 = 6'b100101;
            5'h0A: tab6 = 6'b010101;
            5'h0B: tab6 = 6'b110100;
            5'h0C: tab6 = 6'b001101;
            5'h0D: tab6 = 6'b101100;
            5'h0E: tab6 = 6'b011100;
            5'h0F: tab6 = 6'b010111;
            5'h10: tab6 = 6'b011011;
            5'h11: tab6 = 6'b100011;
            5'h12: tab6 = 6'b010011;
            5'h13: tab6 = 6'b110010;
            5'h14: tab6 = 6'b001011;
            5'h15: tab6 = 6'b101010;
            5'h16: tab6 = 6'b011010;
            5'h17: tab6 = 6'b111010;
            5'h18: tab6 = 6'b110011;
            5'h19: tab6 = 6'b100110;
            5'h1A: tab6 = 6'b010110;
            5'h1B: tab6 = 6'b110110;
            5'h1C: tab6 = 6'b001110;
            5'h1D: tab6 = 6'b101110;
            5'h1E: tab6 = 6'b011110;
            default: tab6 = 6'b101011;
        endcase
    endfunction : tab6

    function automatic logic [3:0] tab4(input logic [2:0] y, input logic k);
        case (y)
            3'h0: tab4 = 4'b1011;
            3'h1: tab4 = k ? 4'b0110 : 4'b1001;
            3'h2: tab4 = k ? 4'b1010 : 4'b0101;
            3'h3: tab4 = 4'b1100;
            3'h4: tab4 = 4'b1101;
            3'h5: tab4 = k ? 4'b0101 : 4'b1010;
            3'h6: tab4 = k ? 4'b1001 : 4'b0110;
            default: tab4 = k ? 4'b0111 : 4'b1110;
        endcase
    endfunction : tab4

    ////////////////////////////////////////////////////////////////////////
    // Encode; only K28.y control groups are produced
    always_comb begin
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] s6;
        logic [3:0] s4;
        logic rd6;
        logic alt;
        x = tx_i.data[4:0];
        y = tx_i.data[7:5];
        s6 = tx_i.k ? GPC_K28_6B : tab6(x);
        // Unbalanced groups and D.7 flip when disparity is positive
        if (st_r.rd_pos && (popc({4'h0, s6}) != 4'h3 ||
                (!tx_i.k && x == 5'h07))) begin
            s6 = ~s6; // see [RL1]
        end
        rd6 = st_r.rd_pos ^ (popc({4'h0, s6}) != 4'h3);
        // Alternate .7 avoids a run of five equal bits
        alt = !tx_i.k && y == 3'h7 &&
            ((!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
             (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        s4 = alt ? 4'b0111 : tab4(y, tx_i.k);
        if (rd6 && (tx_i.k || popc({6'h00, s4}) != 4'h2 || y == 3'h3)) begin
            s4 = ~s4; // see [RL1]
        end
        st_nxt = st_r;
        st_nxt.vld = tx_i.valid;
        if (tx_i.valid) begin
            st_nxt.rd_pos = rd6 ^ (popc({6'h00, s4}) != 4'h2); // see [RL1]
            // Serializer sends bit 9 first, so bit a must land there
            st_nxt.word = rev10(rev10({s6, s4})); // see [RL2]
        end
    end

    // Disparity starts negative
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0; // see [RL20]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign word_o = st_r.word;
    assign vld_o = st_r.vld;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_code_balance: assert property ( // see [RL1]
        vld_o |-> popc(word_o) inside {4'h4, 4'h5, 4'h6})
        else $error("code group disparity out of range");

    a_rd_follows: assert property ( // see [RL1]
        vld_o && popc(word_o) != 4'h5 |->
        st_r.rd_pos == (popc(word_o) == 4'h6))
        else $error("running disparity not tracked");

    a_comma_order: assert property ( // see [RL2]
        tx_i.valid && tx_i.k && tx_i.data == GPC_K28_5 |=>
        word_o == GPC_COMMA_NEG || word_o == GPC_COMMA_POS)
        else $error("comma not sent first bit first");

endmodule : gpc_enc8b10b

// File: design/gpc_pcs_datapath.sv
// Notes on behaviour
// [RL1] Each MAC byte becomes one 10-bit group with correct running disparity.
// [RL2] Every encoded word keeps bit a in bit 9, unreversed, so bit a leaves the line first.
// [RL3] Best of eight serial clock phases is chosen for slip and deserializer.
// [RL4] Serial stream is packed into 10-bit words for the reversal stage.
// [RL5] Optional receive reversal for far ends sending least bit first.
// [RL6] Word boundary locks on the first K28.5 comma found.
// [RL7] Each slip request adds one bit of latency to the stream.
// [RL8] The channel has its own slip request input.
// [RL9] Slip requests stay high and low at least one word each.
// [RL10] Slip acts on the rising edge only; a held request slips once.
// [RL11] Shifted data appears two words after the edge; earlier words ignored.
// [RL12] Rollover point is 10; up to 11 positions, then back to zero.
// [RL13] Rollover flag shows when the rollover point is reached.
// [RL14] Aligned words are checked for code patterns, then fed to sync.
// [RL15] Synchronization machine uses hysteresis against brief errors.
// [RL16] Sync is declared after three consecutive qualifying ordered sets.
// [RL17] A qualifying set is a comma followed by an odd count of data groups.
// [RL18] Word rate is the serial rate divided by ten.
// [RL19] Encoder and transmit reversal run on the core clock.
// [RL20] Encoder disparity starts negative after reset.
module gpc_pcs_datapath
    import gpc_pkg::*;
#(
    parameter logic [3:0] ROLL_PT = GPC_ROLL_PT
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Register port
    input wire gpc_bus_t bus_i,
    output logic [15:0] rd_data_o,
    // Transmit side
    input wire gpc_tx_t tx_i,
    output logic [9:0] tx_word_o,
    output logic tx_vld_o,
    // Serial receive side, sampled by the chosen phase
    input wire logic rx_bit_i,
    input wire logic rx_bit_en_i,
    input wire logic [7:0] rx_edge_i,
    input wire logic slip_req_i,
    // Receive results
    output logic [9:0] rx_word_o,
    output logic rx_vld_o,
    output logic [2:0] phase_sel_o,
    output logic rollover_o,
    output logic sync_o
);

    // The slip window is twenty bits, so ten is the deepest offset
    if (ROLL_PT == 4'h0 || ROLL_PT > GPC_ROLL_PT) begin : g_bad_roll
        $error("ROLL_PT must lie in 1..10");
    end

    typedef struct packed {
        logic rx_rev;
        logic auto_en;
        logic [15:0] rd_data;
        logic [3:0] bit_cnt;
        logic [9:0] shreg;
        logic wstb;
        logic [9:0] prev;
        logic [9:0] cur;
        logic req_d;
        logic [3:0] slip_cnt;
        logic rollover;
        logic [1:0] wait_cnt;
        logic auto_req;
        logic locked;
        logic [9:0] out_word;
        logic out_vld;
        logic [2:0] phase;
        gpc_sync_t sync;
        logic in_set;
        logic odd;
        logic [2:0] err_cnt;
        logic [1:0] good_cnt;
        logic sync_up;
    } gpc_st_t;

    gpc_st_t st_r;
    gpc_st_t st_nxt;
    logic slip_edge;
    logic slip_clr;
    logic [19:0] win;
    logic [9:0] aligned;

    ////////////////////////////////////////////////////////////////////////
    // Code pattern checks
    function automatic logic is_comma(input logic [9:0] w);
        is_comma = w == GPC_COMMA_NEG || w == GPC_COMMA_POS;
    endfunction : is_comma

    // Disparity-legal and free of any comma prefix
    function automatic logic is_data(input logic [9:0] w);
        is_data = popc(w) inside {4'h4, 4'h5, 4'h6} &&
            w[9:3] != GPC_C7_NEG && w[9:3] != GPC_C7_POS;
    endfunction : is_data

    ////////////////////////////////////////////////////////////////////////
    // Transmit path on the core clock
    gpc_enc8b10b u_enc ( // see [RL19]
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .tx_i(tx_i),
        .word_o(tx_word_o),
        .vld_o(tx_vld_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Slip request edge and the shifting window
    assign slip_edge = st_r.wstb & ~st_r.req_d &
        (slip_req_i | st_r.auto_req); // see [RL8] [RL10]
    assign slip_clr = bus_i.wr && bus_i.addr == GPC_A_CTRL &&
        bus_i.wdata[GPC_C_SLIPCLR];
    assign win = {st_r.prev, st_r.cur};
    // Deeper offsets reach back into the previous word
    assign aligned = win[st_r.slip_cnt +: 10]; // see [RL7]

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic comma;
        logic good;
        logic judge;
        logic [2:0] ph;
        comma = is_comma(st_r.out_word);
        good = comma | is_data(st_r.out_word); // see [RL14]
        // Words still in flight from a slip are not judged
        judge = st_r.out_vld && st_r.wait_cnt == 2'h0; // see [RL11]
        ph = 3'h0;
        st_nxt = st_r;
        st_nxt.wstb = 1'b0;
        st_nxt.out_vld = 1'b0;

        // Register writes and reads
        if (bus_i.wr && bus_i.addr == GPC_A_CTRL) begin
            st_nxt.rx_rev = bus_i.wdata[GPC_C_RXREV];
            st_nxt.auto_en = bus_i.wdata[GPC_C_AUTO];
        end
        st_nxt.rd_data = 16'h0000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                GPC_A_CTRL: begin
                    st_nxt.rd_data[GPC_C_RXREV] = st_r.rx_rev;
                    st_nxt.rd_data[GPC_C_AUTO] = st_r.auto_en;
                end
                GPC_A_STAT: begin
                    st_nxt.rd_data[GPC_S_SYNC] = st_r.sync_up;
                    st_nxt.rd_data[GPC_S_ROLL] = st_r.rollover;
                    st_nxt.rd_data[GPC_S_SLIP +: 4] = st_r.slip_cnt;
                    st_nxt.rd_data[GPC_S_PHASE +: 3] = st_r.phase;
                    st_nxt.rd_data[GPC_S_LOCK] = st_r.locked;
                end
                default: begin
                    st_nxt.rd_data = 16'h0000;
                end
            endcase
        end

        // Deserializer: one word per ten bit times
        if (rx_bit_en_i) begin
            st_nxt.shreg = {st_r.shreg[8:0], rx_bit_i}; // see [RL4]
            if (st_r.bit_cnt == GPC_BIT_LAST) begin
                st_nxt.bit_cnt = 4'h0; // see [RL18]
                st_nxt.prev = st_r.cur;
                st_nxt.cur = {st_r.shreg[8:0], rx_bit_i};
                st_nxt.wstb = 1'b1;
            end else begin
                st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
            end
        end

        // Word stage: phase choice, slip, reversal
        if (st_r.wstb) begin
            // Sample mid-eye: four phases away from the first edge seen
            for (int i = GPC_PHASES - 1; i >= 0; i--) begin
                if (rx_edge_i[i]) begin
                    ph = 3'(i + GPC_PHASES / 2);
                end
            end
            if (|rx_edge_i) begin
                st_nxt.phase = ph; // see [RL3]
            end
            st_nxt.req_d = slip_req_i | st_r.auto_req;
            st_nxt.out_word = st_r.rx_rev ? rev10(aligned) : aligned; // see [RL5]
            st_nxt.out_vld = 1'b1;
            if (slip_edge) begin
                // New offset shows in the word after next
                st_nxt.slip_cnt = (st_r.slip_cnt == ROLL_PT) ? 4'h0 :
                    st_r.slip_cnt + 4'h1; // see [RL7] [RL11] [RL12]
                st_nxt.rollover = st_nxt.slip_cnt == ROLL_PT; // see [RL13]
            end
        end
        if (slip_clr) begin
            st_nxt.slip_cnt = 4'h0;
            st_nxt.rollover = 1'b0;
        end

        // Auto aligner: pulse one word, then wait out the latency
        if (st_r.out_vld) begin
            st_nxt.auto_req = 1'b0; // see [RL9]
            if (st_r.wait_cnt != 2'h0) begin
                st_nxt.wait_cnt = st_r.wait_cnt - 2'h1;
            end
        end
        if (judge && st_r.auto_en && !st_r.locked) begin
            if (comma) begin
                st_nxt.locked = 1'b1; // see [RL6]
            end else begin
                st_nxt.auto_req = 1'b1; // see [RL6]
                st_nxt.wait_cnt = GPC_SLIP_WAIT; // see [RL11]
            end
        end

        // Synchronization machine
        if (judge) begin
            case (st_r.sync)
                GPC_LOS, GPC_ACQ1, GPC_ACQ2: begin
                    if (!good) begin
                        st_nxt.sync = GPC_LOS;
                        st_nxt.in_set = 1'b0;
                        st_nxt.locked = 1'b0;
                    end else if (comma) begin
                        st_nxt.in_set = 1'b1;
                        st_nxt.odd = 1'b0;
                        // A comma closes the set begun by the last one
                        if (st_r.in_set && st_r.odd) begin
                            st_nxt.sync = gpc_sync_t'(st_r.sync + 3'h1); // see [RL16] [RL17]
                        end else begin
                            st_nxt.sync = GPC_LOS; // see [RL17]
                        end
                    end else begin
                        st_nxt.odd = ~st_r.odd; // see [RL17]
                    end
                end
                GPC_SYNC: begin
                    // Errors count up; runs of good words pay them back
                    if (!good) begin
                        st_nxt.good_cnt = 2'h0;
                        if (st_r.err_cnt == GPC_ERR_LAST) begin
                            st_nxt.sync = GPC_LOS; // see [RL15]
                            st_nxt.err_cnt = 3'h0;
                            st_nxt.in_set = 1'b0;
                            st_nxt.locked = 1'b0;
                        end else begin
                            st_nxt.err_cnt = st_r.err_cnt + 3'h1; // see [RL15]
                        end
                    end else if (st_r.err_cnt != 3'h0) begin
                        if (st_r.good_cnt == GPC_GOOD_LAST) begin
                            st_nxt.good_cnt = 2'h0;
                            st_nxt.err_cnt = st_r.err_cnt - 3'h1;
                        end else begin
                            st_nxt.good_cnt = st_r.good_cnt + 2'h1;
                        end
                    end
                end
                default: begin
                    st_nxt.sync = GPC_LOS;
                end
            endcase
        end
        st_nxt.sync_up = st_nxt.sync == GPC_SYNC;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.rx_rev <= GPC_CTRL_RST[GPC_C_RXREV];
            st_r.auto_en <= GPC_CTRL_RST[GPC_C_AUTO];
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign rd_data_o = st_r.rd_data;
    assign rx_word_o = st_r.out_word;
    assign rx_vld_o = st_r.out_vld;
    assign phase_sel_o = st_r.phase;
    assign rollover_o = st_r.rollover;
    assign sync_o = st_r.sync_up;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_slip_step: assert property ( // see [RL7]
        slip_edge && !slip_clr |=> st_r.slip_cnt ==
        (($past(st_r.slip_cnt) == ROLL_PT) ? 4'h0 :
         $past(st_r.slip_cnt) + 4'h1))
        else $error("slip did not add one bit");

    a_slip_held: assert property ( // see [RL10]
        st_r.wstb && st_r.req_d && (slip_req_i | st_r.auto_req) &&
        !slip_clr |=> $stable(st_r.slip_cnt))
        else $error("held request slipped again");

    a_slip_range: assert property ( // see [RL12]
        st_r.slip_cnt <= ROLL_PT)
        else $error("slip offset past rollover point");

    a_roll_flag: assert property ( // see [RL13]
        $rose(rollover_o) |-> $past(slip_edge) && st_r.slip_cnt == ROLL_PT)
        else $error("rollover flag without reaching point");

    a_deser_word: assert property ( // see [RL4]
        st_r.wstb |-> $past(st_r.bit_cnt) == GPC_BIT_LAST &&
        $past(rx_bit_en_i))
        else $error("word formed off the ten bit boundary");

    a_judge_wait: assert property ( // see [RL11]
        st_r.out_vld && st_r.wait_cnt != 2'h0 |=>
        !$rose(st_r.auto_req) && $stable(st_r.sync))
        else $error("word judged during slip latency");

    a_auto_low: assert property ( // see [RL9]
        $fell(st_r.auto_req) |-> (!st_r.auto_req) [*8])
        else $error("slip request low time too short");

    a_sync_three: assert property ( // see [RL16]
        $rose(sync_o) |-> $past(st_r.sync) == GPC_ACQ2)
        else $error("sync without three ordered sets");

    a_qual_odd: assert property ( // see [RL17]
        st_r.sync != GPC_SYNC && st_nxt.sync != GPC_LOS &&
        st_nxt.sync != st_r.sync |-> st_r.odd && st_r.in_set)
        else $error("ordered set counted with even data");

    a_hyst_hold: assert property ( // see [RL15]
        st_r.sync == GPC_SYNC && st_r.err_cnt == 3'h0 |=> sync_o)
        else $error("single error dropped sync");

    a_rx_order: assert property ( // see [RL5]
        st_r.wstb && !st_r.rx_rev |=> rx_vld_o &&
        rx_word_o == $past(aligned))
        else $error("receive word reordered without request");

    a_phase_pick: assert property ( // see [RL3]
        st_r.wstb && $onehot(rx_edge_i) |=>
        $past(rx_edge_i) == 8'h01 << (phase_sel_o ^ 3'h4))
        else $error("phase not chosen opposite the edge");

    c_sync_up: cover property ($rose(sync_o));
    c_roll_wrap: cover property (rollover_o ##1 !rollover_o);
    c_auto_slip: cover property ($rose(st_r.auto_req));
    c_sync_loss: cover property ($fell(sync_o));

endmodule : gpc_pcs_datapath

// File: verif/gpc_far_model.sv
module gpc_far_model (
    // Clock
    input wire logic sys_clk_i,
    // Serial line toward the receiver
    output logic rx_bit_o,
    output logic rx_bit_en_o,
    output logic [7:0] rx_edge_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Transitions only on phase 2, so the centre phase is 6
    initial begin
        rx_bit_o = 1'b0;
        rx_bit_en_o = 1'b0;
        rx_edge_o = 8'h04;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit 9 leaves first; idle line shows the inverse of the last bit so a
    // stale value can never pass for a real one
    task automatic send(input logic [9:0] w, input int n);
        for (int i = 9; i > 9 - n; i--) begin
            @(posedge sys_clk_i);
            rx_bit_o <= w[i];
            rx_bit_en_o <= 1'b1;
        end
        @(posedge sys_clk_i);
        rx_bit_en_o <= 1'b0;
        rx_bit_o <= ~rx_bit_o;
    endtask : send
endmodule : gpc_far_model

// File: verif/tb_top.sv
module tb_top
    import gpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i, rst_b_i, slip_req_i, rx_bit, rx_bit_en, ok;
    logic tx_vld_o, rx_vld_o, rollover_o, sync_o, watch, rev;
    gpc_bus_t bus_i;
    gpc_tx_t tx_i;
    logic [15:0] rd_data_o, rd;
    logic [9:0] tx_word_o, rx_word_o;
    logic [7:0] rx_edge;
    logic [2:0] phase_sel_o;
    logic [3:0] exp;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Rows of {k, character, expected group}, disparity carried row to row
    logic [18:0] rows [6] = '{{1'b1, 8'hBC, 10'h0FA}, {1'b1, 8'hBC, 10'h305},
        {1'b0, 8'hB5, 10'h2AA}, {1'b0, 8'h50, 10'h1B5},
        {1'b0, 8'h50, 10'h245}, {1'b0, 8'h00, 10'h274}};

    gpc_pcs_datapath #(.ROLL_PT(GPC_ROLL_PT)) gpc_pcs_datapath_inst (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
        .rd_data_o(rd_data_o), .tx_i(tx_i), .tx_word_o(tx_word_o),
        .tx_vld_o(tx_vld_o), .rx_bit_i(rx_bit), .rx_bit_en_i(rx_bit_en),
        .rx_edge_i(rx_edge), .slip_req_i(slip_req_i), .rx_word_o(rx_word_o),
        .rx_vld_o(rx_vld_o), .phase_sel_o(phase_sel_o),
        .rollover_o(rollover_o), .sync_o(sync_o));
    gpc_far_model gpc_far_model_inst (.sys_clk_i(sys_clk_i),
        .rx_bit_o(rx_bit), .rx_bit_en_o(rx_bit_en), .rx_edge_o(rx_edge));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling well above the 1230 or so needed
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            failures++;
            end_of_test();
        end
    end
    // Received words checked only while whole sets are in flight
    always @(posedge sys_clk_i) begin
        #1;
        ok = rev ? rx_word_o inside {10'h155, 10'h17C, 10'h283}
                 : rx_word_o inside {10'h0FA, 10'h305, 10'h2AA};
        if (watch && rx_vld_o) begin
            chk("rx_word", 16'h0001, {15'h0, ok});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        bus_i <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk_i);
        bus_i <= '0;
    endtask : wr
    // Data stand only in the cycle after the strobe
    task automatic rdr(input logic [1:0] a);
        @(posedge sys_clk_i);
        bus_i <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge sys_clk_i);
        bus_i <= '0;
        #1 rd = rd_data_o;
    endtask : rdr
    // Comma then one data group: an odd count, disparity alternating
    task automatic pairs(input int n);
        for (int i = 0; i < n; i++) begin
            gpc_far_model_inst.send(i[0] ? GPC_COMMA_POS : GPC_COMMA_NEG, 10);
            gpc_far_model_inst.send(10'h2AA, 10);
        end
        repeat (4) @(posedge sys_clk_i);
    endtask : pairs
    // High for hi whole words, then low for a whole word
    task automatic slip(input int hi);
        @(posedge sys_clk_i);
        slip_req_i <= 1'b1;
        repeat (hi) gpc_far_model_inst.send(10'h2AA, 10);
        // Held past the last word's strobe so that word sees it high
        @(posedge sys_clk_i);
        slip_req_i <= 1'b0;
        gpc_far_model_inst.send(10'h2AA, 10);
        repeat (3) @(posedge sys_clk_i);
        rdr(GPC_A_STAT);
    endtask : slip
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b_i = 1'b0;
        bus_i = '0;
        tx_i = '0;
        slip_req_i = 1'b0;
        watch = 1'b0;
        rev = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        #1 chk("reset", 16'h0000, {tx_word_o, sync_o, tx_vld_o, rx_vld_o});
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rdr(GPC_A_CTRL);
        chk("ctrl", GPC_CTRL_RST, rd);
        wr(2'h2, 16'hFFFF);
        rdr(2'h2);
        chk("unmapped", 16'h0000, rd);
        // Characters back to back, each checked the cycle after
        @(posedge sys_clk_i);
        tx_i <= {1'b1, rows[0][18:10]};
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk_i);
            tx_i <= (i < 5) ? {1'b1, rows[i + 1][18:10]} : 10'h000;
            #1 chk("tx", {1'b1, rows[i][9:0]}, {tx_vld_o, tx_word_o});
        end
        // Stream starts three bits off, the aligner must find the comma
        gpc_far_model_inst.send(10'h3FF, 3);
        pairs(30);
        rdr(GPC_A_STAT);
        chk("sync", 16'h00F6, {sync_o, rd[0], phase_sel_o, rd[8:6]});
        watch = 1'b1;
        pairs(2);
        watch = 1'b0;
        wr(GPC_A_CTRL, 16'h0003);
        rev = 1'b1;
        watch = 1'b1;
        pairs(2);
        watch = 1'b0;
        wr(GPC_A_CTRL, 16'h0002);
        rev = 1'b0;
        // One bad group is absorbed, a burst drops sync
        gpc_far_model_inst.send(10'h000, 10);
        pairs(1);
        chk("sync_hold", 16'h0001, {15'h0, sync_o});
        repeat (4) gpc_far_model_inst.send(10'h000, 10);
        repeat (4) @(posedge sys_clk_i);
        chk("sync_lost", 16'h0000, {15'h0, sync_o});
        // Manual slips: a held request counts once, then walk to rollover
        wr(GPC_A_CTRL, 16'h0004);
        slip(3);
        chk("slip_held", 16'h0001, {12'h0, rd[5:2]});
        for (int i = 2; i < 12; i++) begin
            slip(1);
            exp = 4'(i % 11);
            chk("slip", {exp == 4'hA, exp == 4'hA, exp},
                {rollover_o, rd[GPC_S_ROLL], rd[5:2]});
        end
        end_of_test();
    end
endmodule : tb_top
